// file: core/serial_link_if.sv
// serial lines between the uart device and the remote node
`timescale 1ns/1ps
interface serial_link_if;
    logic device_txd; // device to node, idle high
    logic node_txd; // node to device, idle high

    modport device (output device_txd, input node_txd);
    modport node (output node_txd, input device_txd);
endinterface : serial_link_if

// file: core/uart_device.sv
// nine-bit uart with receive filtering, break detect and transmit double buffer
`timescale 1ns/1ps
module uart_device (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [uart_nine_bit_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [7:0] rd_data,
    output logic device_reset_req,
    serial_link_if.device link
);
    import uart_nine_bit_pkg::*;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_e;
    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;

    logic [1:0] mode;
    logic address_filter_enable, rx_enable, transmit_ninth_bit;
    logic received_ninth_bit, tx_flag, receive_flag;
    logic double_buffer_enable, end_interrupt_select;
    logic interrupt_timing_select, error_select_bit, break_reset_enable;
    logic break_flag, framing_error_flag;
    logic [7:0] serial_data_buffer, baud_div, baud_cnt;
    logic tick, nine, port_on, wr_ctl, wr_st, wr_buf;
    rx_state_e rx_state;
    tx_state_e tx_state;
    logic rx_meta, rx_sync, rx_prev;
    logic [3:0] rx_phase, rx_idx;
    logic [1:0] rx_samples;
    logic [8:0] rx_shift;
    logic [7:0] brk_cnt;
    logic rx_bit, rx_decide, rx_final, filter_bit, rx_accept, fe_set;
    logic break_set;
    logic [3:0] tx_phase, tx_idx;
    logic [7:0] tx_data, hold_data;
    logic tx_ninth, hold_ninth, hold_valid, early_done;
    logic tx_bit_end, stop_start, stop_end, load_now, tx_flag_set, tx_bit;

    // register decode and mode decode
    assign nine = is_nine_bit(mode);
    assign port_on = mode != MODE_SYNC;
    assign wr_ctl = wr_strobe && addr == REG_CONTROL;
    assign wr_st = wr_strobe && addr == REG_STATUS;
    assign wr_buf = wr_strobe && addr == REG_DATA;

    // control register; flags clear by writing 0, a set wins
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {receive_flag, tx_flag, received_ninth_bit, transmit_ninth_bit,
             rx_enable, address_filter_enable, mode} <= CONTROL_RESET;
        end else begin
            if (wr_ctl) begin
                mode <= wr_data[CTL_MODE +: 2];
                address_filter_enable <= wr_data[CTL_ADDR_FILTER];
                rx_enable <= wr_data[CTL_RX_ENABLE];
                transmit_ninth_bit <= wr_data[CTL_TX_NINTH];
            end
            tx_flag <= (wr_ctl ? wr_data[CTL_TX_FLAG] : tx_flag) | tx_flag_set;
            receive_flag <= (wr_ctl ? wr_data[CTL_RX_FLAG] : receive_flag)
                | rx_accept;
            if (rx_accept) begin
                received_ninth_bit <= filter_bit;
            end
        end
    end

    // status register; error and break flags clear by writing 0
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {double_buffer_enable, end_interrupt_select,
             interrupt_timing_select, error_select_bit, break_reset_enable,
             break_flag, framing_error_flag} <= STATUS_RESET[7:1];
        end else begin
            if (wr_st) begin
                double_buffer_enable <= wr_data[ST_DOUBLE_BUF];
                end_interrupt_select <= wr_data[ST_END_INT];
                interrupt_timing_select <= wr_data[ST_TIMING];
                error_select_bit <= wr_data[ST_ERR_SEL];
                break_reset_enable <= wr_data[ST_BREAK_RESET];
            end
            break_flag <= (wr_st ? wr_data[ST_BREAK] : break_flag) | break_set;
            framing_error_flag <= (wr_st ? wr_data[ST_FRAME_ERR]
                : framing_error_flag) | fe_set;
        end
    end

    // baud divider and registers that are not flags
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            baud_div <= BAUD_RESET;
            baud_cnt <= 8'h00;
            serial_data_buffer <= 8'h00;
        end else begin
            baud_cnt <= tick ? 8'h00 : baud_cnt + 8'h01;
            if (wr_strobe && addr == REG_BAUD) begin
                baud_div <= wr_data;
            end
            if (rx_accept) begin
                serial_data_buffer <= rx_shift[7:0];
            end
        end
    end
    // a divisor lowered below the running count still ticks at once
    assign tick = baud_cnt >= baud_div;

    // read data, one cycle after the strobe
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data <= 8'h00;
        end else if (rd_strobe) begin
            unique case (addr)
                REG_DATA: rd_data <= serial_data_buffer;
                REG_CONTROL: rd_data <= {receive_flag, tx_flag,
                    received_ninth_bit, transmit_ninth_bit, rx_enable,
                    address_filter_enable, mode};
                REG_STATUS: rd_data <= {double_buffer_enable,
                    end_interrupt_select, interrupt_timing_select,
                    error_select_bit, break_reset_enable, break_flag,
                    framing_error_flag, tx_state == TX_SHIFT};
                REG_BAUD: rd_data <= baud_div;
            endcase
        end
    end

    // receive line synchroniser
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {rx_meta, rx_sync, rx_prev} <= 3'h7;
        end else begin
            {rx_meta, rx_sync, rx_prev} <= {link.node_txd, rx_meta, rx_sync};
        end
    end

    // majority of the three samples, decided at state 9
    assign rx_bit = (rx_samples[0] & rx_samples[1])
        | (rx_sync & (rx_samples[0] | rx_samples[1]));
    assign rx_decide = tick && rx_phase == SAMPLE_LAST;
    // with error select 0 the last shift is the ninth bit
    assign rx_final = rx_decide && ((rx_state == RX_BITS && nine
        && !error_select_bit && rx_idx == 4'h8)
        || (rx_state == RX_STOP && !(nine && !error_select_bit)));
    assign filter_bit = (rx_state == RX_STOP && nine) ? rx_shift[8] : rx_bit;
    // acceptance, otherwise the frame is dropped
    assign rx_accept = rx_final && !receive_flag
        && (!address_filter_enable || filter_bit);
    // filtered ninth bit 0 with error select 1 hides the error
    assign fe_set = rx_decide && rx_state == RX_STOP && !rx_bit
        && !(address_filter_enable && nine && error_select_bit
        && !rx_shift[8]);

    // receive frame sequencer
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_state <= RX_IDLE;
            rx_phase <= 4'h0;
            rx_idx <= 4'h0;
            rx_samples <= 2'h3;
            rx_shift <= 9'h000;
        end else if (rx_state == RX_IDLE) begin
            // falling edge restarts the divide-by-16 count
            if (rx_enable && port_on && rx_prev && !rx_sync) begin
                rx_state <= RX_START;
                rx_phase <= 4'h0;
            end
        end else if (tick) begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase == SAMPLE_FIRST) begin
                rx_samples[0] <= rx_sync;
            end
            if (rx_phase == SAMPLE_MID) begin
                rx_samples[1] <= rx_sync;
            end
            if (rx_phase == SAMPLE_LAST) begin
                unique case (rx_state)
                    // false start bit goes back to idle
                    RX_START: begin
                        rx_state <= rx_bit ? RX_IDLE : RX_BITS;
                        rx_idx <= 4'h0;
                    end
                    RX_BITS: begin
                        rx_shift[rx_idx] <= rx_bit;
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == (nine ? 4'h8 : 4'h7)) begin
                            rx_state <= RX_STOP;
                        end
                    end
                    RX_STOP: rx_state <= RX_IDLE;
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // eleven bit times of low line, 16 ticks each
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            brk_cnt <= 8'h00;
            device_reset_req <= 1'b0;
        end else begin
            if (tick) begin
                if (rx_sync || !port_on) begin
                    brk_cnt <= 8'h00;
                end else if (brk_cnt != BREAK_TICKS) begin
                    brk_cnt <= brk_cnt + 8'h01;
                end
            end
            device_reset_req <= break_set && rx_enable && break_reset_enable;
        end
    end
    assign break_set = tick && !rx_sync && port_on
        && brk_cnt == BREAK_TICKS - 8'h01;

    // transmit timing events
    assign tx_bit_end = tx_state == TX_SHIFT && tick && tx_phase == PHASE_END;
    assign stop_start = tx_bit_end && tx_idx == stop_pos(mode) - 4'h1;
    assign stop_end = tx_bit_end && tx_idx == stop_pos(mode);
    // mode 0 is not served, writes do not start a frame
    assign load_now = wr_buf && port_on && tx_state == TX_IDLE && !hold_valid;

    always_comb begin
        if (!double_buffer_enable) begin
            // conventional flag at the start of the stop bit
            tx_flag_set = stop_start;
        end else begin
            tx_flag_set = load_now
                || (stop_start && !interrupt_timing_select
                    && (hold_valid || end_interrupt_select))
                || (stop_end && (interrupt_timing_select
                    ? (hold_valid || end_interrupt_select)
                    : (hold_valid && !early_done)));
        end
    end

    // transmit shifter and holding buffer
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_state <= TX_IDLE;
            tx_phase <= 4'h0;
            tx_idx <= 4'h0;
            tx_data <= 8'h00;
            tx_ninth <= 1'b0;
            hold_data <= 8'h00;
            hold_ninth <= 1'b0;
            hold_valid <= 1'b0;
            early_done <= 1'b0;
        end else begin
            if (load_now) begin
                tx_state <= TX_SHIFT;
                tx_phase <= 4'h0;
                tx_idx <= 4'h0;
                tx_data <= wr_data;
                // ninth bit captured with the byte, sent only in double mode
                tx_ninth <= transmit_ninth_bit;
                early_done <= 1'b0;
            end else if (tx_state == TX_SHIFT && tick) begin
                tx_phase <= tx_phase + 4'h1;
                if (tx_bit_end) begin
                    tx_idx <= tx_idx + 4'h1;
                end
                // an early end flag cannot be withdrawn
                if (stop_start && !interrupt_timing_select
                        && (hold_valid || end_interrupt_select)) begin
                    early_done <= 1'b1;
                end
                // next word follows after one stop bit
                if (stop_end) begin
                    if (double_buffer_enable && hold_valid) begin
                        tx_idx <= 4'h0;
                        tx_data <= hold_data;
                        tx_ninth <= hold_ninth;
                        hold_valid <= 1'b0;
                        early_done <= 1'b0;
                    end else begin
                        tx_state <= TX_IDLE;
                    end
                end
            end
            // only the double mode accepts a write while busy
            if (wr_buf && double_buffer_enable && port_on && !load_now) begin
                hold_data <= wr_data;
                hold_ninth <= transmit_ninth_bit;
                hold_valid <= 1'b1;
            end
        end
    end

    // current line level; single mode sends the live ninth bit
    always_comb begin
        if (tx_state == TX_IDLE || tx_idx == stop_pos(mode)) begin
            tx_bit = 1'b1;
        end else if (tx_idx == 4'h0) begin
            tx_bit = 1'b0;
        end else if (tx_idx == BIT_NINTH) begin
            tx_bit = double_buffer_enable ? tx_ninth : transmit_ninth_bit;
        end else begin
            tx_bit = tx_data[3'(tx_idx - 4'h1)];
        end
    end

    // registered transmit pin
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            link.device_txd <= 1'b1;
        end else begin
            link.device_txd <= tx_bit;
        end
    end
endmodule : uart_device

// file: core/uart_nine_bit_pkg.sv
// constants, register map and timing shared by both ends of the serial link
// Notes on behaviour
// - accept frame only if flag clear, filter passes
// - failed acceptance drops frame, no receive flag
// - ninth bit to flag, eight bits to buffer
// - error select 0: flag at ninth bit
// - error select 1: flag, error at stop
// - eleven low bit times flag a break
// - break span covers whole frame plus stop
// - break flag holds until cleared or reset
// - enabled break with reset enable resets device
// - holding buffer gives back to back characters
// - double buffer bit selects single or double
// - software uses double buffer only async modes
// - empty holding buffer: load, interrupt at once
// - last word: end interrupt per select bits
// - waiting word: load, interrupt per timing select
// - avoid writes during last stop bit
// - single buffer: ninth bit stable until sent
// - double buffer: ninth bit buffered with data
// - master marks address ninth bit one
// - filter bit zero in mode 1, ignored mode 0
// - 16x sampling, majority of 7,8,9, start check
package uart_nine_bit_pkg;
    localparam int ADDR_W = 2;
    localparam logic [1:0] REG_DATA = 2'h0;
    localparam logic [1:0] REG_CONTROL = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [1:0] REG_BAUD = 2'h3;
    // control register fields
    localparam int CTL_MODE = 0;
    localparam int CTL_ADDR_FILTER = 2;
    localparam int CTL_RX_ENABLE = 3;
    localparam int CTL_TX_NINTH = 4;
    localparam int CTL_RX_NINTH = 5;
    localparam int CTL_TX_FLAG = 6;
    localparam int CTL_RX_FLAG = 7;
    // status register fields
    localparam int ST_DOUBLE_BUF = 7;
    localparam int ST_END_INT = 6;
    localparam int ST_TIMING = 5;
    localparam int ST_ERR_SEL = 4;
    localparam int ST_BREAK_RESET = 3;
    localparam int ST_BREAK = 2;
    localparam int ST_FRAME_ERR = 1;
    localparam int ST_TX_BUSY = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h15;
    // modes
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_EIGHT = 2'h1;
    // receive sampling
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] SAMPLE_FIRST = 4'h7;
    localparam logic [3:0] SAMPLE_MID = 4'h8;
    localparam logic [3:0] SAMPLE_LAST = 4'h9;
    localparam logic [3:0] PHASE_END = 4'hF;
    localparam int BREAK_BITS = 11;
    localparam logic [7:0] BREAK_TICKS = 8'(BREAK_BITS * OVERSAMPLE);
    // frame bit positions: 0 start, 1..8 data, 9 ninth
    localparam logic [3:0] BIT_NINTH = 4'h9;
    localparam logic [3:0] STOP_EIGHT = 4'h9;
    localparam logic [3:0] STOP_NINE = 4'hA;

    // modes 2 and 3 carry a ninth data bit
    function automatic logic is_nine_bit(input logic [1:0] mode);
        return mode[1];
    endfunction : is_nine_bit

    // position of the stop bit for a mode
    function automatic logic [3:0] stop_pos(input logic [1:0] mode);
        return mode[1] ? STOP_NINE : STOP_EIGHT;
    endfunction : stop_pos
endpackage : uart_nine_bit_pkg

// file: core/uart_node.sv
// remote serial node: sends and receives 8 or 9 bit frames
`timescale 1ns/1ps
module uart_node #(
    parameter int TICK_DIV = 22
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic nine_bit_mode,
    input wire logic send_valid,
    input wire logic [8:0] send_data,
    input wire logic send_break,
    output logic send_ready,
    output logic recv_valid,
    output logic [8:0] recv_data,
    output logic recv_frame_error,
    serial_link_if.node link
);
    import uart_nine_bit_pkg::*;

    logic [15:0] tick_cnt;
    logic tick, rx_meta, rx_sync, rx_prev, rx_busy, tx_busy;
    logic [3:0] rx_phase, rx_idx, tx_phase, tx_idx, last;
    logic [8:0] rx_shift, tx_shift;

    // 16x tick divider
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
        end
    end
    assign tick = tick_cnt == 16'(TICK_DIV - 1);
    assign last = nine_bit_mode ? STOP_NINE : STOP_EIGHT;

    // ninth bit of send_data marks an address byte
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_busy <= 1'b0;
            tx_phase <= 4'h0;
            tx_idx <= 4'h0;
            tx_shift <= 9'h000;
            send_ready <= 1'b0;
            link.node_txd <= 1'b1;
        end else begin
            send_ready <= !tx_busy && !send_valid && !send_break;
            if (!tx_busy && send_valid && send_ready) begin
                tx_busy <= 1'b1;
                tx_phase <= 4'h0;
                tx_idx <= 4'h0;
                tx_shift <= send_data;
                link.node_txd <= 1'b0;
            end else if (tx_busy && tick) begin
                tx_phase <= tx_phase + 4'h1;
                if (tx_phase == PHASE_END) begin
                    tx_idx <= tx_idx + 4'h1;
                    if (tx_idx == last) begin
                        tx_busy <= 1'b0;
                    end else if (tx_idx + 4'h1 == last) begin
                        link.node_txd <= 1'b1;
                    end else begin
                        link.node_txd <= tx_shift[tx_idx];
                    end
                end
            end else if (!tx_busy) begin
                link.node_txd <= !send_break;
            end
        end
    end

    // two-stage synchroniser on the device's transmit line
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {rx_meta, rx_sync, rx_prev} <= 3'h7;
        end else begin
            {rx_meta, rx_sync, rx_prev} <= {link.device_txd, rx_meta, rx_sync};
        end
    end

    // receiver sampling each bit at its middle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_busy <= 1'b0;
            rx_phase <= 4'h0;
            rx_idx <= 4'h0;
            rx_shift <= 9'h000;
            recv_valid <= 1'b0;
            recv_data <= 9'h000;
            recv_frame_error <= 1'b0;
        end else begin
            recv_valid <= 1'b0;
            if (!rx_busy) begin
                if (rx_prev && !rx_sync) begin
                    rx_busy <= 1'b1;
                    rx_phase <= 4'h0;
                    rx_idx <= 4'h0;
                    rx_shift <= 9'h000;
                end
            end else if (tick) begin
                rx_phase <= rx_phase + 4'h1;
                if (rx_phase == SAMPLE_MID) begin
                    rx_idx <= rx_idx + 4'h1;
                    if (rx_idx == 4'h0 && rx_sync) begin
                        rx_busy <= 1'b0;
                    end else if (rx_idx == last) begin
                        rx_busy <= 1'b0;
                        recv_valid <= 1'b1;
                        recv_data <= rx_shift;
                        recv_frame_error <= !rx_sync;
                    end else if (rx_idx != 4'h0) begin
                        rx_shift[rx_idx - 4'h1] <= rx_sync;
                    end
                end
            end
        end
    end
endmodule : uart_node

// file: tb/uart_link_sva.sv
// wire-level checks on the serial link between device and node
`timescale 1ns/1ps
module uart_link_sva (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic device_txd,
    input wire logic node_txd,
    input wire logic device_reset_req
);
    logic [7:0] dlow;
    logic [7:0] nlow;
    // low run lengths of both lines, saturating
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dlow <= 8'h00;
            nlow <= 8'h00;
        end else begin
            dlow <= device_txd ? 8'h00 : dlow + 8'(dlow != 8'hFF);
            nlow <= node_txd ? 8'h00 : nlow + 8'(nlow != 8'hFF);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_idle_after_reset: assert property (
        $fell(reset) |-> device_txd && node_txd) else $error("not idle");
    a_start_bit_len: assert property (
        $fell(device_txd) |-> (!device_txd)[*8] ##1 (!device_txd)[*8])
        else $error("short low bit");
    a_low_whole_bits: assert property (
        $rose(device_txd) |-> dlow[3:0] == 4'h0) else $error("odd low run");
    a_low_run_max: assert property (
        dlow <= 8'hA0) else $error("low run too long");
    a_high_min_dev: assert property (
        $rose(device_txd) |-> device_txd[*8] ##1 device_txd[*8])
        else $error("short high bit");
    a_high_min_node: assert property (
        $rose(node_txd) |-> node_txd[*8]) else $error("short node high");
    a_node_whole_bits: assert property (
        $rose(node_txd) |-> nlow[3:0] == 4'h0) else $error("odd node low");
    a_break_req_cause: assert property (
        device_reset_req |-> nlow >= 8'hB0) else $error("early break");
    a_break_req_pulse: assert property (
        device_reset_req |=> !device_reset_req) else $error("long request");
    c_break_req: cover property (device_reset_req);
    c_dev_frame: cover property ($rose(device_txd));
    c_node_frame: cover property ($fell(node_txd));
endmodule : uart_link_sva

// file: tb/uart_nine_bit_double_buffered_tb.sv
// self-checking bench joining the uart device and the remote node
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module uart_nine_bit_double_buffered_tb;
    import uart_nine_bit_pkg::*;
    logic sys_clk, reset, wr_strobe, rd_strobe, device_reset_req, was_rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wr_data, rd_data, r;
    logic nine_bit_mode, send_valid, send_break, send_ready, recv_valid;
    logic recv_frame_error;
    logic [7:0] exp_rd;
    logic [8:0] exp_rx;
    logic [8:0] send_data, recv_data;
    logic [7:0] rd_q[$];
    logic [8:0] rx_q[$];
    int n_errors, samples_checked, reqs;
    serial_link_if link ();
    uart_device i_uart_device (.sys_clk(sys_clk), .reset(reset),
        .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rd_data(rd_data),
        .device_reset_req(device_reset_req), .link(link));
    uart_node #(.TICK_DIV(1)) i_uart_node (.sys_clk(sys_clk), .reset(reset),
        .nine_bit_mode(nine_bit_mode), .send_valid(send_valid),
        .send_data(send_data), .send_break(send_break),
        .send_ready(send_ready), .recv_valid(recv_valid),
        .recv_data(recv_data), .recv_frame_error(recv_frame_error),
        .link(link));
    uart_link_sva i_uart_link_sva (.sys_clk(sys_clk), .reset(reset),
        .device_txd(link.device_txd), .node_txd(link.node_txd),
        .device_reset_req(device_reset_req));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // compare read data and received frames against the oldest note
    always @(posedge sys_clk) begin
        was_rd <= rd_strobe;
        if (device_reset_req === 1'b1) reqs++;
        if (was_rd === 1'b1) begin
            exp_rd = rd_q.pop_front();
            `CHK("rd_data", exp_rd, rd_data)
        end
        if (recv_valid === 1'b1) begin
            exp_rx = rx_q.pop_front();
            `CHK("recv_data", exp_rx, recv_data)
            `CHK("recv_stop", 1'b0, recv_frame_error)
        end
    end
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge sys_clk);
        wr_strobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        rd_q.push_back(e);
        @(posedge sys_clk);
        rd_strobe <= 1'b0;
    endtask : rd
    // bounded wait for node ready or for the frame notes to drain
    task automatic wait_for(input bit on_queue);
        int i;
        for (i = 0; i < 8000; i++) begin
            if (on_queue ? rx_q.size() == 0 : send_ready === 1'b1) break;
            @(posedge sys_clk);
        end
        if (i == 8000) begin
            n_errors++;
            end_of_test();
        end
    endtask : wait_for
    task automatic send(input logic [8:0] d, input int probe,
            input logic [7:0] pe);
        wait_for(1'b0);
        send_valid <= 1'b1;
        send_data <= d;
        @(posedge sys_clk);
        send_valid <= 1'b0;
        @(posedge sys_clk);
        // optional control read part way through the frame
        if (probe > 0) begin
            repeat (probe) @(posedge sys_clk);
            rd(REG_CONTROL, pe);
        end
        wait_for(1'b0);
        repeat (32) @(posedge sys_clk);
    endtask : send
    initial begin
        reset = 1'b1;
        {addr, wr_data, wr_strobe, rd_strobe, send_valid, send_break} = '0;
        send_data = 9'h000;
        nine_bit_mode = 1'b1;
        void'($urandom(32'h302a_5f2a));
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(REG_CONTROL, CONTROL_RESET);
        rd(REG_STATUS, STATUS_RESET);
        rd(REG_BAUD, BAUD_RESET);
        wr(REG_BAUD, 8'h00);
        $display("registers test done");
        wr(REG_CONTROL, 8'h0B);
        send(9'h155, 0, 8'h00);
        rd(REG_DATA, 8'h55);
        rd(REG_CONTROL, 8'hAB);
        send(9'h0A3, 0, 8'h00);
        rd(REG_DATA, 8'h55);
        nine_bit_mode <= 1'b0;
        // filter kept off in mode 1
        wr(REG_CONTROL, 8'h09);
        send(9'h0C6, 0, 8'h00);
        rd(REG_DATA, 8'hC6);
        rd(REG_CONTROL, 8'hA9);
        nine_bit_mode <= 1'b1;
        $display("receive test done");
        for (int es = 0; es < 2; es++) begin
            wr(REG_STATUS, 8'(es << ST_ERR_SEL));
            wr(REG_CONTROL, 8'h0F);
            r = 8'($urandom);
            send({1'b0, r}, 0, 8'h00);
            rd(REG_CONTROL, 8'h2F);
            // flag at ninth or stop bit
            send({1'b1, r}, 160, es != 0 ? 8'h2F : 8'hAF);
            rd(REG_DATA, r);
            rd(REG_CONTROL, 8'hAF);
            rd(REG_STATUS, 8'(es << ST_ERR_SEL));
        end
        $display("filter test done");
        // double buffer in mode 3 only
        wr(REG_STATUS, 8'h80);
        wr(REG_CONTROL, 8'h1B);
        r = 8'($urandom);
        rx_q.push_back({1'b1, r});
        wr(REG_DATA, r);
        rd(REG_CONTROL, 8'h7B);
        wr(REG_CONTROL, 8'h0B);
        rx_q.push_back({1'b0, ~r});
        // hold write well before stop bit
        wr(REG_DATA, ~r);
        rd(REG_CONTROL, 8'h2B);
        repeat (170) @(posedge sys_clk);
        rd(REG_CONTROL, 8'h6B);
        wr(REG_CONTROL, 8'h0B);
        wait_for(1'b1);
        repeat (20) @(posedge sys_clk);
        rd(REG_CONTROL, 8'h2B);
        wr(REG_STATUS, 8'h00);
        // ninth bit set before the byte
        wr(REG_CONTROL, 8'h1B);
        rx_q.push_back({1'b1, 8'h3C});
        wr(REG_DATA, 8'h3C);
        rd(REG_CONTROL, 8'h3B);
        wait_for(1'b1);
        rd(REG_CONTROL, 8'h7B);
        $display("transmit test done");
        wr(REG_STATUS, 8'h08);
        wr(REG_CONTROL, 8'h0B);
        @(posedge sys_clk);
        send_break <= 1'b1;
        repeat (192) @(posedge sys_clk);
        send_break <= 1'b0;
        repeat (32) @(posedge sys_clk);
        `CHK("reset requests", 1, reqs)
        rd(REG_STATUS, 8'h0E);
        wr(REG_STATUS, 8'h08);
        rd(REG_STATUS, 8'h08);
        repeat (2) @(posedge sys_clk);
        $display("break test done");
        end_of_test();
    end
endmodule : uart_nine_bit_double_buffered_tb
